// ### common/mbr_pkg.sv
// Constants and types for the memory bus redundancy recovery block.
// Assumes one system clock and initialization shared by all nodes.
package mbr_pkg;

  // ==========================================================
  // Bus-pair state encodings, bits ABCD
  localparam logic [3:0] BS_NULL = 4'h0;
  localparam logic [3:0] BS_PRIM_UP = 4'h8;
  localparam logic [3:0] BS_BACK_UP = 4'h2;
  localparam logic [3:0] BS_NORMAL = 4'hA;
  localparam logic [3:0] BS_XCHG = 4'h5;
  localparam logic [3:0] BS_PRIM_DN = 4'h3;
  localparam logic [3:0] BS_BACK_DN = 4'hC;

  // A: own bus on own range, B: own bus on partner range
  localparam int BS_A_POS = 3;
  localparam int BS_B_POS = 2;
  localparam int BS_C_POS = 1;
  localparam int BS_D_POS = 0;

  // ==========================================================
  // Interleave type field
  localparam logic [1:0] ILV_ONE = 2'h0;
  localparam logic [1:0] ILV_TWO64 = 2'h1;
  localparam logic [1:0] ILV_TWO128 = 2'h2;
  localparam logic [1:0] ILV_FOUR = 2'h3;

  // ==========================================================
  // Bus identifier arithmetic
  localparam logic [2:0] PAIR_XOR = 3'h2;
  localparam logic [2:0] ILV64_XOR = 3'h1;
  localparam logic [2:0] ILV128_XOR = 3'h2;
  localparam int BUS_ID_MID_POS = 1;

  // ==========================================================
  // Commands, internal events and sequencer states
  typedef enum logic [1:0] {
    CMD_TOGGLE = 2'h0,
    CMD_ATTACH = 2'h1,
    CMD_DETACH = 2'h2,
    CMD_XCHG = 2'h3
  } mbr_cmd_t;

  typedef enum logic [2:0] {
    EV_NONE = 3'h0,
    EV_OWN_DN = 3'h1,
    EV_PART_DN = 3'h2,
    EV_OWN_UP = 3'h3,
    EV_PART_UP = 3'h4,
    EV_XCHG = 3'h5,
    EV_TOGGLE = 3'h6
  } mbr_evt_t;

  typedef enum logic [3:0] {
    SEQ_IDLE = 4'h1,
    SEQ_REPORT = 4'h2,
    SEQ_RETRY = 4'h4,
    SEQ_APPLY = 4'h8
  } mbr_seq_t;

  function automatic logic mbr_legal(input logic [3:0] s);
    return (s == BS_NULL) || (s == BS_PRIM_UP) || (s == BS_BACK_UP) ||
           (s == BS_NORMAL) || (s == BS_XCHG) || (s == BS_PRIM_DN) ||
           (s == BS_BACK_DN);
  endfunction

endpackage

// ### common/mbr_step_if.sv
// Carrier between the sequencer and the bus-state step logic.
// Assumes both ends sit in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
interface mbr_step_if;
  import mbr_pkg::*;
  logic [3:0] cur;
  mbr_evt_t evt;
  logic four_way;
  logic [3:0] nxt;
  modport ctrl (output cur, output evt, output four_way, input nxt);
  modport step (input cur, input evt, input four_way, output nxt);
endinterface
`default_nettype wire

// ### rtl/mbr_step.sv
// Next bus-pair state for one recovery event.
// Assumes the caller applies the result only at the retry point.
`timescale 1ns/1ps
`default_nettype none
module mbr_step (
  mbr_step_if.step s
);
  import mbr_pkg::*;

  // ==========================================================
  // Transition table, four-way and two-way variants
  always_comb begin
    s.nxt = s.cur;
    unique case (s.evt)
      EV_OWN_DN: begin
        if (s.cur == BS_NORMAL || s.cur == BS_XCHG || s.cur == BS_PRIM_UP) begin
          s.nxt = BS_PRIM_DN;
        end
      end
      EV_PART_DN: begin
        if (s.cur == BS_NORMAL || s.cur == BS_XCHG || s.cur == BS_BACK_UP) begin
          s.nxt = BS_BACK_DN;
        end
      end
      EV_OWN_UP: begin
        // Two-way: returning bus comes back as spare only
        if (s.cur == BS_PRIM_DN) begin
          s.nxt = s.four_way ? BS_NORMAL : BS_BACK_UP;
        end
      end
      EV_PART_UP: begin
        if (s.cur == BS_BACK_DN) begin
          s.nxt = s.four_way ? BS_NORMAL : BS_PRIM_UP;
        end
      end
      EV_XCHG: begin
        // Null and failed-bus states (0000, 0011, 1100) keep their value
        if (s.cur == BS_NORMAL) begin
          s.nxt = BS_XCHG;
        end else if (s.cur == BS_XCHG) begin
          s.nxt = BS_NORMAL;
        end else if (s.cur == BS_PRIM_UP) begin
          s.nxt = BS_BACK_UP;
        end else if (s.cur == BS_BACK_UP) begin
          s.nxt = BS_PRIM_UP;
        end
      end
      EV_NONE, EV_TOGGLE: begin
        s.nxt = s.cur;
      end
      default: begin
        s.nxt = s.cur;
      end
    endcase
  end

endmodule
`default_nettype wire

// ### rtl/mbr_top.sv
// Bus-pair redundancy control for one switch or memory controller node.
// Assumes error reporting and retry sequencing live outside, same clock.
//
// Contract
// - Buses pair only as 0-2, 1-3, 4-6, 5-7.
// - Interleave type 00/01/10/11 encodes one-, two-64, two-128, four-way.
// - Module interleave bit never affects bus switching.
// - Controller four-way flag used for recovery only, not recognition.
// - Four bus-state bits, directly writable for diagnostics or initialization.
// - State 0000 at init without redundancy; no memory accesses.
// - State 1010 at init with redundancy; both buses serve all accesses.
// - State 1000: own bus active, partner inactive.
// - State 0010: own bus inactive, spare-side normal.
// - State 0101: both active on exchanged back-up ranges.
// - Permanent own-bus failure leads to 0011.
// - Partner failure leads to 1100, serving both ranges.
// - Each command raises an error report and a retry.
// - Toggle flips bus-id middle bit on controllers only; state untouched.
// - Attach activates the back-up partner of the receiving bus.
// - Detach follows the permanent-failure recovery path.
// - Interchange swaps roles of partnered buses; others unaffected.
// - Two-way 64 pairs buses 0-1; two-way 128 pairs 0-2.
// - Two-bus redundancy keeps one bus spare.
// - Four-way switch node falls back to two-way on partner failure.
// - Controller selects one of two buses, switching during retry.
`timescale 1ns/1ps
`default_nettype none
module mbr_top (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Node configuration
  input wire logic node_is_mcu_i,
  input wire logic redundant_enable_i,
  input wire logic [2:0] init_bus_id_i,
  input wire logic [1:0] interleave_type_i,
  input wire logic module_interleave_i,
  input wire logic four_way_flag_i,
  // Direct state write
  input wire logic state_wr_i,
  input wire logic [3:0] state_wdata_i,
  output logic state_wr_reject_o,
  // Reconfiguration commands
  input wire logic cmd_valid_i,
  input wire mbr_pkg::mbr_cmd_t cmd_code_i,
  input wire logic cmd_own_bus_i,
  output logic cmd_reject_o,
  output logic busy_o,
  // Permanent failure events
  input wire logic own_fail_i,
  input wire logic partner_fail_i,
  // Error report and retry
  output logic err_report_o,
  output logic retry_req_o,
  input wire logic retry_done_i,
  // Status
  output logic [3:0] bus_state_o,
  output logic [2:0] bus_id_o,
  output logic [2:0] partner_id_o,
  output logic [2:0] ilv_peer_o,
  output logic bus_select_o,
  output logic prim_range_en_o,
  output logic back_range_en_o,
  output logic mem_access_en_o,
  output logic partner_active_o,
  output logic [1:0] recog_mode_o,
  output logic mod_interleave_o,
  output logic four_way_o
);
  import mbr_pkg::*;

  // ==========================================================
  // Declarations
  mbr_seq_t seq_reg;
  mbr_seq_t seq_next;
  mbr_evt_t evt_reg;
  mbr_evt_t evt_next;
  mbr_evt_t cmd_evt;
  logic [3:0] state_reg;
  logic [3:0] state_next;
  logic [2:0] bus_id_reg;
  logic [2:0] bus_id_next;
  logic is_mcu_reg;
  logic [1:0] ilv_reg;
  logic fw_flag_reg;
  logic fw_eff;
  logic own_pend_reg;
  logic part_pend_reg;
  logic own_fail_any;
  logic part_fail_any;
  logic fail_take;
  logic cmd_ok;
  logic cmd_take;
  logic wr_take;
  logic [1:0] recog_next;
  logic [2:0] peer_next;

  mbr_step_if step_bus ();

  mbr_step u_step (
    .s(step_bus)
  );

  // ==========================================================
  // Configuration capture
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      is_mcu_reg <= 1'b0;
      ilv_reg <= ILV_ONE;
      fw_flag_reg <= 1'b0;
    end else begin
      is_mcu_reg <= node_is_mcu_i;
      ilv_reg <= interleave_type_i;
      fw_flag_reg <= four_way_flag_i;
    end
  end

  // Recovery mode: switch uses its type field, controller its flag
  assign fw_eff = is_mcu_reg ? fw_flag_reg : (ilv_reg == ILV_FOUR);

  // ==========================================================
  // Failures pending while a sequence runs; clear beats set for the failure being taken
  assign own_fail_any = own_fail_i || own_pend_reg;
  assign part_fail_any = partner_fail_i || part_pend_reg;
  assign fail_take = (seq_reg == SEQ_IDLE) && (own_fail_any || part_fail_any);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      own_pend_reg <= 1'b0;
    end else if (own_fail_i && !(seq_reg == SEQ_IDLE)) begin
      own_pend_reg <= 1'b1;
    end else if (fail_take && own_fail_any) begin
      own_pend_reg <= 1'b0;
    end
  end

  // Own failure goes first; partner failure waits one more sequence
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      part_pend_reg <= 1'b0;
    end else if (partner_fail_i && !(fail_take && !own_fail_any)) begin
      part_pend_reg <= 1'b1;
    end else if (fail_take && !own_fail_any) begin
      part_pend_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Command decode
  always_comb begin
    cmd_evt = EV_NONE;
    unique case (cmd_code_i)
      CMD_TOGGLE: cmd_evt = EV_TOGGLE;
      CMD_ATTACH: cmd_evt = cmd_own_bus_i ? EV_PART_UP : EV_OWN_UP;
      CMD_DETACH: cmd_evt = cmd_own_bus_i ? EV_OWN_DN : EV_PART_DN;
      CMD_XCHG: cmd_evt = EV_XCHG;
      default: cmd_evt = EV_NONE;
    endcase
  end

  // Toggle is meaningless for a switch node
  assign cmd_ok = !(cmd_code_i == CMD_TOGGLE && !is_mcu_reg);
  assign cmd_take = cmd_valid_i && cmd_ok && (seq_reg == SEQ_IDLE) && !fail_take;
  assign wr_take = state_wr_i && mbr_legal(state_wdata_i) && (seq_reg == SEQ_IDLE) &&
                   !fail_take && !cmd_take;

  // ==========================================================
  // Report and retry sequencer
  always_comb begin
    seq_next = seq_reg;
    evt_next = evt_reg;
    if (rst_i) begin
      seq_next = SEQ_IDLE;
      evt_next = EV_NONE;
    end else begin
      unique case (seq_reg)
        SEQ_IDLE: begin
          if (fail_take) begin
            // Failure was already reported by the detecting node
            seq_next = SEQ_RETRY;
            evt_next = own_fail_any ? EV_OWN_DN : EV_PART_DN;
          end else if (cmd_take) begin
            seq_next = SEQ_REPORT;
            evt_next = cmd_evt;
          end
        end
        SEQ_REPORT: seq_next = SEQ_RETRY;
        SEQ_RETRY: begin
          if (retry_done_i) begin
            seq_next = SEQ_APPLY;
          end
        end
        SEQ_APPLY: begin
          seq_next = SEQ_IDLE;
          evt_next = EV_NONE;
        end
        default: begin
          seq_next = SEQ_IDLE;
          evt_next = EV_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    seq_reg <= seq_next;
    evt_reg <= evt_next;
  end

  // ==========================================================
  // Bus-pair state and bus identifier
  assign step_bus.cur = state_reg;
  assign step_bus.evt = evt_reg;
  assign step_bus.four_way = fw_eff;

  always_comb begin
    state_next = state_reg;
    if (rst_i) begin
      state_next = redundant_enable_i ? BS_NORMAL : BS_NULL;
    end else if (seq_reg == SEQ_APPLY) begin
      state_next = step_bus.nxt;
    end else if (wr_take) begin
      state_next = state_wdata_i;
    end
  end

  always_comb begin
    bus_id_next = bus_id_reg;
    if (rst_i) begin
      bus_id_next = init_bus_id_i;
    end else if (seq_reg == SEQ_APPLY && evt_reg == EV_TOGGLE) begin
      bus_id_next = bus_id_reg ^ (3'h1 << BUS_ID_MID_POS);
    end
  end

  always_ff @(posedge clk_i) begin
    state_reg <= state_next;
    bus_id_reg <= bus_id_next;
  end

  // ==========================================================
  // Address recognition mode and interleave peer
  always_comb begin
    recog_next = ILV_ONE;
    if (!is_mcu_reg) begin
      recog_next = ilv_reg;
      // Own bus also carries partner slice: four-way halves to two-way
      if (ilv_reg == ILV_FOUR && state_next[BS_A_POS] && state_next[BS_B_POS]) begin
        recog_next = ILV_TWO64;
      end
    end
  end

  always_comb begin
    peer_next = bus_id_next;
    if (ilv_reg == ILV_TWO64) begin
      peer_next = bus_id_next ^ ILV64_XOR;
    end else if (ilv_reg == ILV_TWO128) begin
      peer_next = bus_id_next ^ ILV128_XOR;
    end
  end

  // ==========================================================
  // Registered outputs, taken from next values except four_way_o
  always_ff @(posedge clk_i) begin
    bus_state_o <= state_next;
    bus_id_o <= bus_id_next;
    partner_id_o <= bus_id_next ^ PAIR_XOR;
    ilv_peer_o <= peer_next;
    prim_range_en_o <= state_next[BS_A_POS];
    back_range_en_o <= state_next[BS_B_POS];
    mem_access_en_o <= state_next[BS_A_POS] || state_next[BS_B_POS];
    partner_active_o <= state_next[BS_C_POS] || state_next[BS_D_POS];
    recog_mode_o <= recog_next;
    four_way_o <= rst_i ? 1'b0 : fw_eff;
  end

  // Module interleave bit is passed on and touches nothing else
  always_ff @(posedge clk_i) begin
    mod_interleave_o <= rst_i ? 1'b0 : module_interleave_i;
  end

  // Primary-down controller sits on the partner bus
  always_ff @(posedge clk_i) begin
    bus_select_o <= is_mcu_reg && (bus_id_next[BUS_ID_MID_POS] ^
                    (state_next == BS_PRIM_DN));
  end

  always_ff @(posedge clk_i) begin
    err_report_o <= (seq_next == SEQ_REPORT);
    retry_req_o <= (seq_next == SEQ_RETRY);
    busy_o <= (seq_next != SEQ_IDLE);
    cmd_reject_o <= !rst_i && cmd_valid_i && !cmd_take;
    state_wr_reject_o <= !rst_i && state_wr_i && !wr_take;
  end

  // ==========================================================
  // Checks
  property p_pair;
    @(posedge clk_i) disable iff (rst_i)
      partner_id_o == (bus_id_o ^ PAIR_XOR);
  endproperty
  a_pair: assert property (p_pair) else $error("partner id not fixed pair");

  property p_init;
    @(posedge clk_i) disable iff (rst_i)
      $fell(rst_i) |-> bus_state_o == ($past(redundant_enable_i) ? BS_NORMAL : BS_NULL);
  endproperty
  a_init: assert property (p_init) else $error("wrong init bus state");

  property p_null_idle;
    @(posedge clk_i) disable iff (rst_i)
      (bus_state_o == BS_NULL) |-> !mem_access_en_o && !prim_range_en_o;
  endproperty
  a_null_idle: assert property (p_null_idle) else $error("access in null state");

  property p_cmd_report;
    @(posedge clk_i) disable iff (rst_i)
      cmd_take |=> err_report_o && busy_o ##1 retry_req_o && !err_report_o;
  endproperty
  a_cmd_report: assert property (p_cmd_report) else $error("command without report");

  property p_toggle;
    @(posedge clk_i) disable iff (rst_i)
      (seq_reg == SEQ_APPLY && evt_reg == EV_TOGGLE) |=>
        (bus_id_o[BUS_ID_MID_POS] != $past(bus_id_o[BUS_ID_MID_POS])) &&
        $stable(bus_state_o);
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle effect wrong");

  property p_detach;
    @(posedge clk_i) disable iff (rst_i)
      (seq_reg == SEQ_APPLY && evt_reg == EV_OWN_DN && state_reg == BS_NORMAL) |=>
        bus_state_o == BS_PRIM_DN && !mem_access_en_o;
  endproperty
  a_detach: assert property (p_detach) else $error("detach did not drop bus");

  property p_legal;
    @(posedge clk_i) disable iff (rst_i)
      mbr_legal(bus_state_o);
  endproperty
  a_legal: assert property (p_legal) else $error("illegal bus state");

  property p_spare;
    @(posedge clk_i) disable iff (rst_i)
      (!fw_eff && $changed(bus_state_o)) |-> bus_state_o != BS_NORMAL;
  endproperty
  a_spare: assert property (p_spare) else $error("spare bus activated");

  property p_degrade;
    @(posedge clk_i) disable iff (rst_i)
      (!is_mcu_reg && $stable(is_mcu_reg) && ilv_reg == ILV_FOUR && $stable(ilv_reg) &&
       bus_state_o == BS_BACK_DN) |-> recog_mode_o == ILV_TWO64;
  endproperty
  a_degrade: assert property (p_degrade) else $error("no two-way fallback");

  property p_select;
    @(posedge clk_i) disable iff (rst_i)
      (is_mcu_reg && $stable(is_mcu_reg)) |->
        bus_select_o == (bus_id_o[BUS_ID_MID_POS] ^ (bus_state_o == BS_PRIM_DN));
  endproperty
  a_select: assert property (p_select) else $error("bus select mismatch");

endmodule
`default_nettype wire

// ### bench/mbr_retry_partner.sv
// Model of the retry logic beside the node: answers each retry request.
// Assumes one clock shared with the node; delay_i sets how slow it is.
`timescale 1ns/1ps
`default_nettype none
module mbr_retry_partner (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Retry handshake
  input wire logic retry_req_i,
  input wire logic [3:0] delay_i,
  output logic retry_done_o
);
  // ==========================================================
  // Retry answer
  initial begin
    retry_done_o = 1'b0;
    forever begin
      @(negedge clk_i);
      if (retry_req_i && !rst_i) begin
        repeat (delay_i) @(negedge clk_i);
        @(posedge clk_i);
        retry_done_o <= 1'b1;
        @(posedge clk_i);
        retry_done_o <= 1'b0;
        // Wait for the request to drop, so one retry is answered once
        do @(negedge clk_i); while (retry_req_i);
      end
    end
  end
endmodule
`default_nettype wire

// ### bench/memory_bus_redundancy_recovery_bench.sv
// Self-checking bench for mbr_top: commands, failures, direct writes.
// Assumes the retry partner model closes every retry sequence.
`timescale 1ns/1ps
`default_nettype none
module memory_bus_redundancy_recovery_bench;
  import mbr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic is_mcu = 1'b1;
  logic red_en = 1'b0;
  logic [1:0] ilv_type = 2'h3;
  logic mod_ilv = 1'b0;
  logic fw_flag = 1'b1;
  logic wr = 1'b0;
  logic [3:0] wdata = 4'h0;
  logic cmd_valid = 1'b0;
  mbr_cmd_t cmd_code = CMD_TOGGLE;
  logic cmd_own = 1'b1;
  logic own_fail = 1'b0;
  logic part_fail = 1'b0;
  logic [3:0] delay = 4'h0;
  logic retry_done, wr_rej, cmd_rej, busy, err_rep, retry_req, bus_sel;
  logic prim_en, back_en, mem_en, part_act, mod_ilv_o, four_way;
  logic [3:0] bus_state;
  logic [2:0] bus_id, part_id, ilv_peer;
  logic [1:0] recog;
  logic [2:0] exp_id = 3'h2;
  logic [2:0] exp_peer;
  int n_errors = 0;
  int samples_checked = 0;

  // ==========================================================
  // Design and partner
  mbr_top DUT (.clk_i(clk_i), .rst_i(rst_i), .node_is_mcu_i(is_mcu),
    .redundant_enable_i(red_en), .init_bus_id_i(3'h2), .interleave_type_i(ilv_type),
    .module_interleave_i(mod_ilv), .four_way_flag_i(fw_flag), .state_wr_i(wr),
    .state_wdata_i(wdata), .state_wr_reject_o(wr_rej), .cmd_valid_i(cmd_valid),
    .cmd_code_i(cmd_code), .cmd_own_bus_i(cmd_own), .cmd_reject_o(cmd_rej),
    .busy_o(busy), .own_fail_i(own_fail), .partner_fail_i(part_fail),
    .err_report_o(err_rep), .retry_req_o(retry_req), .retry_done_i(retry_done),
    .bus_state_o(bus_state), .bus_id_o(bus_id), .partner_id_o(part_id),
    .ilv_peer_o(ilv_peer), .bus_select_o(bus_sel), .prim_range_en_o(prim_en),
    .back_range_en_o(back_en), .mem_access_en_o(mem_en), .partner_active_o(part_act),
    .recog_mode_o(recog), .mod_interleave_o(mod_ilv_o), .four_way_o(four_way));

  mbr_retry_partner partner (.clk_i(clk_i), .rst_i(rst_i), .retry_req_i(retry_req),
    .delay_i(delay), .retry_done_o(retry_done));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  // ==========================================================
  // Tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [3:0] seen, input logic [3:0] exp, input string what);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic st(input logic [3:0] s);
    chk(bus_state, s, "bus state");
    chk({prim_en, back_en, mem_en, part_act}, {s[3], s[2], s[3] | s[2], s[1] | s[0]},
      "range enables");
    chk({1'b0, bus_id}, {1'b0, exp_id}, "bus id");
    chk({1'b0, part_id}, {1'b0, exp_id ^ 3'h2}, "partner id");
    chk(4'(bus_sel), 4'(is_mcu & (exp_id[1] ^ (s == 4'h3))), "bus select");
  endtask

  task automatic reset_to(input logic en);
    @(posedge clk_i);
    rst_i <= 1'b1;
    red_en <= en;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
  endtask

  // Kind 0 command, 1 own failure, 2 partner failure, 3 direct write
  task automatic op(input int kind, input mbr_cmd_t c, input logic own,
                    input logic [3:0] wd, input logic rej);
    @(posedge clk_i);
    cmd_valid <= (kind == 0);
    cmd_code <= c;
    cmd_own <= own;
    own_fail <= (kind == 1);
    part_fail <= (kind == 2);
    wr <= (kind == 3);
    wdata <= wd;
    @(posedge clk_i);
    {cmd_valid, own_fail, part_fail, wr} <= 4'h0;
    #1;
    if (kind == 0) chk(4'(rej ? cmd_rej : err_rep), 4'h1, "command answer");
    if (kind == 3) chk(4'(wr_rej), 4'(rej), "write refusal");
    if (kind == 1 || kind == 2) chk(4'(err_rep), 4'h0, "failure report");
    chk(4'(retry_req), 4'(kind == 1 || kind == 2), "retry request");
    for (int i = 0; i < 60 && busy !== 1'b0; i++) begin
      @(posedge clk_i);
      #1;
    end
    chk(4'(busy), 4'h0, "sequence end");
  endtask

  // ==========================================================
  // Watchdog, far longer than the few hundred cycles needed
  initial begin
    #20000;
    n_errors++;
    summarize();
  end

  // ==========================================================
  // Test sequence
  initial begin
    reset_to(1'b0);
    st(BS_NULL);
    reset_to(1'b1);
    st(BS_NORMAL);
    op(0, CMD_TOGGLE, 1'b1, 4'h0, 1'b0);
    exp_id = 3'h0;
    st(BS_NORMAL);
    op(0, CMD_DETACH, 1'b1, 4'h0, 1'b0);
    st(BS_PRIM_DN);
    op(0, CMD_ATTACH, 1'b0, 4'h0, 1'b0);
    st(BS_NORMAL);
    op(0, CMD_XCHG, 1'b1, 4'h0, 1'b0);
    st(BS_XCHG);
    op(0, CMD_XCHG, 1'b1, 4'h0, 1'b0);
    st(BS_NORMAL);
    @(posedge clk_i);
    delay <= 4'h7;
    op(2, CMD_TOGGLE, 1'b1, 4'h0, 1'b0);
    st(BS_BACK_DN);
    op(3, CMD_TOGGLE, 1'b1, BS_NORMAL, 1'b0);
    op(1, CMD_TOGGLE, 1'b1, 4'h0, 1'b0);
    st(BS_PRIM_DN);
    @(posedge clk_i);
    fw_flag <= 1'b0;
    // Two-way bring-up of the spare: attach, then detach and attach from the far side
    op(0, CMD_ATTACH, 1'b0, 4'h0, 1'b0);
    st(BS_BACK_UP);
    op(0, CMD_DETACH, 1'b0, 4'h0, 1'b0);
    st(BS_BACK_DN);
    op(0, CMD_ATTACH, 1'b1, 4'h0, 1'b0);
    st(BS_PRIM_UP);
    op(3, CMD_TOGGLE, 1'b1, BS_PRIM_UP, 1'b0);
    st(BS_PRIM_UP);
    op(0, CMD_XCHG, 1'b1, 4'h0, 1'b0);
    st(BS_BACK_UP);
    op(3, CMD_TOGGLE, 1'b1, 4'h6, 1'b1);
    st(BS_BACK_UP);
    op(3, CMD_TOGGLE, 1'b1, BS_BACK_DN, 1'b0);
    op(0, CMD_ATTACH, 1'b1, 4'h0, 1'b0);
    st(BS_PRIM_UP);
    chk(4'(recog), 4'h0, "controller recognition");
    // Switch node from here on
    @(posedge clk_i);
    is_mcu <= 1'b0;
    op(0, CMD_TOGGLE, 1'b1, 4'h0, 1'b1);
    st(BS_PRIM_UP);
    op(3, CMD_TOGGLE, 1'b1, BS_NORMAL, 1'b0);
    for (int t = 0; t < 4; t++) begin
      @(posedge clk_i);
      ilv_type <= 2'(t);
      mod_ilv <= ~mod_ilv;
      repeat (2) @(posedge clk_i);
      #1;
      exp_peer = (t == 1) ? exp_id ^ 3'h1 : (t == 2) ? exp_id ^ 3'h2 : exp_id;
      chk(4'(recog), 4'(t), "recognition mode");
      chk({1'b0, ilv_peer}, {1'b0, exp_peer}, "interleave peer");
      chk(4'(four_way), 4'(t == 3), "four-way mode");
      chk(4'(mod_ilv_o), 4'(mod_ilv), "module interleave");
      st(BS_NORMAL);
    end
    op(2, CMD_TOGGLE, 1'b1, 4'h0, 1'b0);
    st(BS_BACK_DN);
    chk(4'(recog), 4'(ILV_TWO64), "fallback recognition");
    summarize();
  end
endmodule
`default_nettype wire
